// file: core/cci_ctrl.sv
// Summary of operation
// - Enter calibration only inside power-up window (not timed here; Enter is taken whenever idle)
// - Calibration commands travel over I2C only
// - Packet is address-write, command, two data bytes
// - Commands without data carry two zero bytes
// - Only defined command encodings are sent
// - Commands 00-1F read word, fetch later
// - No new command until previous finishes
// - Poll response until busy code disappears
// - Or wait for ready pin rising
// - Fetch length depends on command kind
// - Scale typical times by 1.1
// - Optional write-back after corrected read
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
module cci_ctrl #(
	parameter int       WRITE_WAIT = cci_pkg::WRITE_CYC,
	parameter logic [6:0] SLAVE_ADDR = cci_pkg::DEF_SLAVE
) (
	input  logic                       aclk,
	input  logic                       aresetn,
	input  logic [cci_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  logic                       s_axi_awvalid,
	output logic                       s_axi_awready,
	input  logic [31:0]                s_axi_wdata,
	input  logic [3:0]                 s_axi_wstrb,
	input  logic                       s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  logic                       s_axi_bready,
	input  logic [cci_pkg::ADDR_W-1:0] s_axi_araddr,
	input  logic                       s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  logic                       s_axi_rready,
	input  logic                       scl_level,
	output logic                       scl_value,
	output logic                       scl_en,
	input  logic                       sda_level,
	output logic                       sda_value,
	output logic                       sda_en,
	input  logic                       dev_ready
);
	import cci_pkg::*;

	typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT, S_FETCH} cci_seq_t;
	typedef struct packed {
		cci_seq_t          state;
		logic [2:0]        step;
		logic              pend;
		logic [7:0]        cmd;
		logic [15:0]       data;
		cci_cls_t          cls;
		logic [6:0]        addr;
		logic              use_rdy;
		logic              rdy_prev;
		logic              done;
		logic              bad;
		logic              refused;
		logic              i2c_err;
		logic              mode_err;
		logic              cal;
		logic [7:0]        resp;
		logic [15:0]       rdat;
		logic              aw_got;
		logic              w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0]       wdat;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} cci_ctl_st_t;

	cci_ctl_st_t      q, d;
	cci_i2c_if        eng_bus ();
	cci_cls_t         new_cls;
	logic             cmd_wr;
	logic             wr_fire;
	logic             rdy_rise;
	logic             tmr_load;
	logic             tmr_exp;
	logic [TMR_W-1:0] tmr_cycles;
	logic [31:0]      wmerge;
	logic [2:0]       stop_step;

	// Sort a command byte; anything undefined is never sent
	function automatic cci_cls_t cls_of(input logic [7:0] c);
		if (c <= CMD_RD_HI)
			return C_READ;
		if (c >= CMD_WR_LO && c <= CMD_WR_HI)
			return C_WRITE;
		if (c == CMD_RESUME)
			return C_RESUME;
		if (c == CMD_ENTER)
			return C_ENTER;
		if (c == CMD_REV)
			return C_REV;
		return C_BAD;
	endfunction

	// Bytes fetched after the response byte
	function automatic logic [2:0] extra_of(input cci_cls_t c);
		if (c == C_READ)
			return XTRA_RD;
		if (c == C_REV)
			return XTRA_REV;
		return 3'h0;
	endfunction

	// Register read view; unmapped words read as zero
	function automatic logic [31:0] reg_word(input logic [ADDR_W-1:0] a);
		case (a)
			A_CMD:   return {8'h00, q.data, q.cmd};
			A_CFG:   return {23'h000000, q.use_rdy, 1'b0, q.addr};
			A_STAT:  return {16'h0000, q.resp, 1'b0, q.cal, q.mode_err, q.i2c_err,
					q.refused, q.bad, q.done, q.state != S_IDLE};
			A_DATA:  return {16'h0000, q.rdat}; // Kept for optional write-back
			default: return 32'h00000000;
		endcase
	endfunction

	// Byte lanes not strobed keep their old value
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] s);
		logic [31:0] m;
		m = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i])
				m[i*8 +: 8] = n[i*8 +: 8];
		end
		return m;
	endfunction

	always_comb begin
		d = q;
		d.rdy_prev = dev_ready;
		tmr_load = 1'b0;
		tmr_cycles = TMR_W'(SHORT_CYC);
		wmerge = merge(reg_word(q.awaddr), q.wdat, q.wstrb);
		new_cls = cls_of(wmerge[7:0]);
		stop_step = (q.state == S_SEND) ? ST_STOP : 3'(ST_XTRA + extra_of(q.cls));
		rdy_rise = dev_ready && !q.rdy_prev;

		// Address and data are taken in either order, answered once both are in
		if (s_axi_awvalid && s_axi_awready) begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			d.w_got = 1'b1;
			d.wdat = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		wr_fire = q.aw_got && q.w_got && !q.bvalid;
		cmd_wr = wr_fire && q.awaddr == A_CMD;
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (wr_fire) begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			case (q.awaddr)
				A_CMD, A_STAT, A_DATA: ;
				A_CFG: begin
					d.addr = wmerge[6:0];
					d.use_rdy = wmerge[CFG_RDY];
				end
				default: d.bresp = RESP_SLVERR;
			endcase
		end

		// One read in flight; the data word is captured when taken
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rdata = reg_word(s_axi_araddr);
			d.rresp = (s_axi_araddr inside {A_CMD, A_CFG, A_STAT, A_DATA}) ?
					RESP_OKAY : RESP_SLVERR;
		end

		// Byte order for the current packet step
		eng_bus.valid = (q.state == S_SEND || q.state == S_FETCH) && !q.pend;
		eng_bus.op = OP_WR;
		eng_bus.wdata = 8'h00;
		eng_bus.ack = 1'b0;
		if (q.step == ST_START)
			eng_bus.op = OP_START;
		else if (q.step == ST_ADDR)
			eng_bus.wdata = {q.addr, q.state == S_FETCH};
		else if (q.step == stop_step)
			eng_bus.op = OP_STOP;
		else if (q.state == S_SEND)
			eng_bus.wdata = (q.step == ST_CMD) ? q.cmd :
					(q.step == ST_DHI) ? q.data[15:8] : q.data[7:0];
		else begin
			eng_bus.op = OP_RD;
			eng_bus.ack = (3'(q.step + 3'h1) < stop_step);
		end
		if (eng_bus.valid && eng_bus.ready)
			d.pend = 1'b1;

		// Byte finished: collect, abort on any refused write byte, close the packet
		if (eng_bus.done) begin
			d.pend = 1'b0;
			d.step = q.step + 3'h1;
			if (q.step == ST_START && q.state == S_FETCH)
				d.rdat = 16'h0000;
			if (eng_bus.op == OP_WR && eng_bus.nack) begin
				d.i2c_err = 1'b1;
				d.step = stop_step;
			end
			if (eng_bus.op == OP_RD) begin
				if (q.step == ST_RESP)
					d.resp = eng_bus.rdata;
				else
					d.rdat = {q.rdat[7:0], eng_bus.rdata};
			end
			if (eng_bus.op == OP_STOP) begin
				d.step = ST_START;
				if (q.state == S_SEND) begin
					if (q.i2c_err || q.cls == C_RESUME) begin
						// Measurement mode answers no fetch, so stop here
						d.state = S_IDLE;
						d.done = 1'b1;
						if (!q.i2c_err)
							d.cal = 1'b0;
					end else begin
						d.state = S_WAIT;
						tmr_load = 1'b1;
						if (q.cls == C_WRITE)
							tmr_cycles = TMR_W'(WRITE_WAIT);
					end
				end else if (!q.i2c_err && q.resp[RB_CODE +: 2] == RC_BUSY) begin
					d.state = S_FETCH;
				end else begin
					// Diagnostic bits stay visible whatever the code says
					d.state = S_IDLE;
					d.done = 1'b1;
					d.mode_err = !q.i2c_err && q.resp[RB_MODE +: 2] != MODE_CAL;
					if (!q.i2c_err && q.cls == C_ENTER && q.resp[RB_CODE +: 2] == RC_ACK)
						d.cal = 1'b1;
				end
			end
		end

		// Waiting: ready pin edge or worst-case time, never both
		if (q.state == S_WAIT && (q.use_rdy ? rdy_rise : tmr_exp)) begin
			d.state = S_FETCH;
			d.step = ST_START;
		end

		// New order from software; only taken while idle
		if (cmd_wr) begin
			if (q.state != S_IDLE) begin
				d.refused = 1'b1;
			end else begin
				d.done = 1'b0;
				d.bad = 1'b0;
				d.refused = 1'b0;
				d.i2c_err = 1'b0;
				d.mode_err = 1'b0;
				d.cmd = wmerge[7:0];
				d.cls = new_cls;
				// Zero data unless the command writes a word
				d.data = (new_cls == C_WRITE) ? wmerge[23:8] : 16'h0000;
				if (new_cls == C_BAD)
					d.bad = 1'b1;
				else if (!q.cal && new_cls != C_ENTER)
					d.refused = 1'b1;
				else begin
					d.state = S_SEND;
					d.step = ST_START;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.addr <= SLAVE_ADDR;
			q.rdy_prev <= 1'b1; // Pin idles high, so no false edge after reset
		end else begin
			q <= d;
		end
	end

	// Bus handshakes
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready = !q.w_got && !q.bvalid;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = !q.rvalid;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	// The serial link is the only path that carries commands
	cci_i2c_eng u_eng (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.bus       (eng_bus.eng),
		.scl_level (scl_level),
		.scl_value (scl_value),
		.scl_en    (scl_en),
		.sda_level (sda_level),
		.sda_value (sda_value),
		.sda_en    (sda_en)
	);

	cci_wait_tmr #(.W(TMR_W)) u_tmr (
		.aclk    (aclk),
		.aresetn (aresetn),
		.load    (tmr_load),
		.cycles  (tmr_cycles),
		.expired (tmr_exp)
	);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_enter_first;
		(q.state == S_IDLE ##1 q.state == S_SEND) |-> (q.cls == C_ENTER || $past(q.cal));
	endproperty
	a_enter_first: assert property (p_enter_first)
		else $error("command sent outside calibration mode");

	property p_addr_byte;
		q.state == S_SEND && q.step == ST_ADDR && eng_bus.valid && eng_bus.ready
			|=> q.pend && eng_bus.wdata == {q.addr, 1'b0};
	endproperty
	a_addr_byte: assert property (p_addr_byte)
		else $error("packet address byte wrong");

	property p_zero_data;
		q.state == S_SEND && q.step >= ST_DHI && q.step < ST_STOP && q.cls != C_WRITE
			|-> eng_bus.wdata == 8'h00;
	endproperty
	a_zero_data: assert property (p_zero_data)
		else $error("nonzero data with dataless command");

	property p_bad_cmd;
		cmd_wr && q.state == S_IDLE && new_cls == C_BAD |=> q.bad && q.state == S_IDLE;
	endproperty
	a_bad_cmd: assert property (p_bad_cmd)
		else $error("undefined command was sent");

	property p_read_cmd;
		q.state == S_SEND && q.cls == C_READ && q.step == ST_CMD && eng_bus.valid
			|-> eng_bus.wdata <= CMD_RD_HI && q.data == 16'h0000;
	endproperty
	a_read_cmd: assert property (p_read_cmd)
		else $error("memory read packet malformed");

	property p_busy_refuse;
		cmd_wr && q.state != S_IDLE |=> q.refused && $stable(q.cmd) && $stable(q.data);
	endproperty
	a_busy_refuse: assert property (p_busy_refuse)
		else $error("command overlapped a running one");

	property p_wait_min;
		$rose(q.state == S_WAIT) && !q.use_rdy |-> (q.state == S_WAIT)[*8];
	endproperty
	a_wait_min: assert property (p_wait_min)
		else $error("wait ended too early");

	property p_poll;
		q.state == S_FETCH && eng_bus.done && eng_bus.op == OP_STOP && !q.i2c_err
			&& q.resp[RB_CODE +: 2] == RC_BUSY |=> q.state == S_FETCH && q.step == ST_START;
	endproperty
	a_poll: assert property (p_poll)
		else $error("busy response not polled again");

	property p_ready_hold;
		q.state == S_WAIT && q.use_rdy && !(dev_ready && !q.rdy_prev) |=> q.state == S_WAIT;
	endproperty
	a_ready_hold: assert property (p_ready_hold)
		else $error("left wait without ready edge");

	property p_fetch_len;
		q.state == S_FETCH && q.step == ST_RESP && eng_bus.valid
			|-> eng_bus.ack == (q.cls == C_READ || q.cls == C_REV);
	endproperty
	a_fetch_len: assert property (p_fetch_len)
		else $error("fetch length wrong for command");
endmodule // cci_ctrl

// file: core/cci_i2c_eng.sv
module cci_i2c_eng #(
	parameter int QTR = cci_pkg::I2C_QTR
) (
	input  logic  aclk,
	input  logic  aresetn,
	cci_i2c_if.eng bus,
	input  logic  scl_level,
	output logic  scl_value,
	output logic  scl_en,
	input  logic  sda_level,
	output logic  sda_value,
	output logic  sda_en
);
	import cci_pkg::*;
	typedef struct packed {
		logic             busy;
		cci_op_t          op;
		logic [1:0]       ph;
		logic [3:0]       nbit;
		logic [8:0]       sh;
		logic [DIV_W-1:0] div;
		logic             scl_lo;
		logic             sda_lo;
		logic [7:0]       rd;
		logic             nack;
		logic             done;
	} cci_eng_st_t;
	cci_eng_st_t q, d;
	logic tick;

	// Four phases per bit; a stretched clock holds the sample phase
	always_comb begin
		d = q;
		d.done = 1'b0;
		tick = (q.div == '0) && (q.ph != PH_SAMP || scl_level);
		if (!q.busy) begin
			if (bus.valid) begin
				d.busy = 1'b1;
				d.op = bus.op;
				d.ph = PH_SET;
				d.nbit = '0;
				d.div = DIV_W'(QTR - 1);
				// Reads release data and drive the answer bit last
				d.sh = (bus.op == OP_WR) ? {bus.wdata, 1'b1} : {8'hFF, ~bus.ack};
			end
		end else if (q.div != '0) begin
			d.div = q.div - 1'b1;
		end else if (tick) begin
			d.div = DIV_W'(QTR - 1);
			d.ph = q.ph + 1'b1;
			case (q.ph)
				PH_SET: begin
					if (q.op == OP_START)
						d.sda_lo = 1'b0;
					else if (q.op == OP_STOP)
						d.sda_lo = 1'b1;
					else
						d.sda_lo = ~q.sh[8];
				end
				PH_RISE: d.scl_lo = 1'b0;
				PH_SAMP: begin
					if (q.op == OP_START)
						d.sda_lo = 1'b1;
					else if (q.op == OP_STOP)
						d.sda_lo = 1'b0;
					else
						d.sh = {q.sh[7:0], sda_level};
				end
				default: begin
					if (q.op != OP_STOP)
						d.scl_lo = 1'b1;
					d.nbit = q.nbit + 1'b1;
					if (q.op == OP_START || q.op == OP_STOP || q.nbit == BIT_LAST) begin
						d.busy = 1'b0;
						d.done = 1'b1;
						d.rd = q.sh[8:1];
						d.nack = q.sh[0];
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	// Open-drain lines: only ever pulled low
	assign scl_value = 1'b0;
	assign sda_value = 1'b0;
	assign scl_en = q.scl_lo;
	assign sda_en = q.sda_lo;
	assign bus.ready = !q.busy;
	assign bus.done = q.done;
	assign bus.rdata = q.rd;
	assign bus.nack = q.nack;
endmodule // cci_i2c_eng

// file: core/cci_i2c_if.sv
// Byte-level orders from the sequencer to the serial engine
interface cci_i2c_if;
	import cci_pkg::*;
	logic           valid;
	logic           ready;
	cci_op_t        op;
	logic [7:0]     wdata;
	logic           ack;
	logic           done;
	logic [7:0]     rdata;
	logic           nack;
	modport ctl (output valid, op, wdata, ack, input ready, done, rdata, nack);
	modport eng (input valid, op, wdata, ack, output ready, done, rdata, nack);
endinterface

// file: core/cci_pkg.sv
package cci_pkg;
	// Clock rate and typical command times
	localparam int CLK_MHZ    = 20;
	localparam int T_SHORT_US = 100;
	localparam int T_WRITE_US = 12000;
	// Oscillator tolerance margin, 1.1 as a fraction
	localparam int TOL_NUM    = 11;
	localparam int TOL_DEN    = 10;
	// Least waits round up to whole cycles
	localparam int SHORT_CYC  = (T_SHORT_US * CLK_MHZ * TOL_NUM + TOL_DEN - 1) / TOL_DEN;
	localparam int WRITE_CYC  = (T_WRITE_US * CLK_MHZ * TOL_NUM + TOL_DEN - 1) / TOL_DEN;
	localparam int TMR_W      = 19;
	// Bus clock of the serial link, four phases per bit
	localparam int KHZ_PER_MHZ = 1000;
	localparam int I2C_KHZ    = 100;
	localparam int I2C_PHASES = 4;
	localparam int I2C_QTR    = (CLK_MHZ * KHZ_PER_MHZ) / (I2C_KHZ * I2C_PHASES);
	localparam int DIV_W      = 16;
	localparam logic [1:0] PH_SET  = 2'h0;
	localparam logic [1:0] PH_RISE = 2'h1;
	localparam logic [1:0] PH_SAMP = 2'h2;
	localparam logic [1:0] PH_FALL = 2'h3;
	localparam logic [3:0] BIT_LAST = 4'h8;
	// Software register map
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] A_CMD  = 4'h0;
	localparam logic [ADDR_W-1:0] A_CFG  = 4'h4;
	localparam logic [ADDR_W-1:0] A_STAT = 4'h8;
	localparam logic [ADDR_W-1:0] A_DATA = 4'hC;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [6:0] DEF_SLAVE   = 7'h28;
	localparam int CFG_RDY = 8;
	// Command byte encodings
	localparam logic [7:0] CMD_RD_HI  = 8'h1F;
	localparam logic [7:0] CMD_WR_LO  = 8'h40;
	localparam logic [7:0] CMD_WR_HI  = 8'h5F;
	localparam logic [7:0] CMD_RESUME = 8'h80;
	localparam logic [7:0] CMD_ENTER  = 8'hA0;
	localparam logic [7:0] CMD_REV    = 8'hB0;
	// Response byte fields
	localparam int RB_CODE = 0;
	localparam int RB_MODE = 6;
	localparam logic [1:0] RC_BUSY  = 2'h0;
	localparam logic [1:0] RC_ACK   = 2'h1;
	localparam logic [1:0] MODE_CAL = 2'h2;
	// Packet steps
	localparam logic [2:0] ST_START = 3'h0;
	localparam logic [2:0] ST_ADDR  = 3'h1;
	localparam logic [2:0] ST_CMD   = 3'h2;
	localparam logic [2:0] ST_RESP  = 3'h2;
	localparam logic [2:0] ST_DHI   = 3'h3;
	localparam logic [2:0] ST_XTRA  = 3'h3;
	localparam logic [2:0] ST_STOP  = 3'h5;
	localparam logic [2:0] XTRA_RD  = 3'h2;
	localparam logic [2:0] XTRA_REV = 3'h1;
	typedef enum logic [1:0] {OP_START, OP_STOP, OP_WR, OP_RD} cci_op_t;
	typedef enum logic [2:0] {C_READ, C_WRITE, C_RESUME, C_ENTER, C_REV, C_BAD} cci_cls_t;
endpackage

// file: core/cci_wait_tmr.sv
module cci_wait_tmr #(
	parameter int W = cci_pkg::TMR_W
) (
	input  logic         aclk,
	input  logic         aresetn,
	input  logic         load,
	input  logic [W-1:0] cycles,
	output logic         expired
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic         run;
		logic         exp;
	} cci_tmr_st_t;
	cci_tmr_st_t q, d;

	// Count down once per cycle; expiry stays up until the next load
	always_comb begin
		d = q;
		if (load) begin
			d.cnt = cycles;
			d.run = 1'b1;
			d.exp = 1'b0;
		end else if (q.run) begin
			if (q.cnt == '0) begin
				d.run = 1'b0;
				d.exp = 1'b1;
			end else begin
				d.cnt = q.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	assign expired = q.exp;
endmodule // cci_wait_tmr

// file: verif/cci_ctrl_tb.sv
module cci_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cci_pkg::*;
	localparam logic [7:0] REV_VAL = 8'h3C; // Arbitrary revision value
	logic        aclk, aresetn, dev_ready, scl_en, sda_en, sda_pull;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          err_total, cmp_count;
	// Open-drain wires with pull-ups
	wire         scl = !scl_en;
	wire         sda = !(sda_en || sda_pull);

	cci_ctrl #(.WRITE_WAIT(300)) i_cci_ctrl (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.scl_level(scl), .scl_value(), .scl_en, .sda_level(sda), .sda_value(), .sda_en,
		.dev_ready
	);
	cci_dev_model #(.ADDR(DEF_SLAVE), .REV(REV_VAL)) i_cci_dev_model (
		.aclk, .scl, .sda, .sda_pull, .ready(dev_ready)
	);

	task automatic end_of_test;
		if (err_total == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// A wait that runs out ends the run as a failure
	task automatic guard(input int n, input int lim);
		if (n > lim) begin
			err_total++;
			end_of_test();
		end
	endtask

	// Write: both channels offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; !(s_axi_bvalid && s_axi_bready); n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			guard(n, 50);
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; !(s_axi_rvalid && s_axi_rready); n++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			guard(n, 50);
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Poll status until done and not busy
	task automatic poll(output logic [31:0] st);
		logic [1:0] r;
		int n;
		st = '0;
		for (n = 0; st[1:0] !== 2'b10; n++) begin
			repeat (20) @(posedge aclk);
			rd(A_STAT, st, r);
			guard(n, 3000);
		end
	endtask

	task automatic cmd(input logic [7:0] c, input logic [15:0] d, output logic [31:0] st);
		logic [1:0] r;
		wr(A_CMD, {8'h00, d, c}, r);
		poll(st);
	endtask

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		rd(A_CFG, d, r);
		chk("cfg reset", {25'h0, DEF_SLAVE}, d);
		rd(A_STAT, d, r);
		chk("stat reset", 32'h0, d);
		rd(4'h2, d, r);
		chk("unmapped read", {d[29:0], RESP_SLVERR}, {d[29:0], r});
		chk("unmapped data", 32'h0, d);
		wr(4'h6, 32'h1, r);
		chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
	endtask

	task automatic t_refuse;
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  bad_c [4] = '{8'h20, 8'h60, 8'hC0, 8'hFF};
		wr(A_CMD, {24'h0, CMD_RD_HI}, r);
		rd(A_STAT, d, r);
		chk("refused", 32'h8, d & 32'h8);
		foreach (bad_c[i]) begin
			wr(A_CMD, {24'h0, bad_c[i]}, r);
			rd(A_STAT, d, r);
			chk("undefined", 32'h4, d & 32'h4);
		end
		chk("nothing sent", 32'h0, {24'h0, i_cci_dev_model.last_cmd});
	endtask

	task automatic t_enter;
		logic [31:0] st;
		cmd(CMD_ENTER, 16'h0000, st);
		chk("enter stat", 32'h8142, st);
		chk("enter data", 32'h0, {16'h0, i_cci_dev_model.last_data});
		chk("enter len", 32'h1, i_cci_dev_model.fetch_len);
	endtask

	task automatic t_write;
		logic [31:0] st;
		cmd(8'h56, 16'hBEEF, st);
		chk("write stat", 32'h8142, st);
		chk("write word", 32'hBEEF, {16'h0, i_cci_dev_model.mem[22]});
		chk("write polls", 32'h1, 32'(i_cci_dev_model.n_fetch > 1));
		cmd(8'h45, 16'h1234, st);
		chk("locked stat", 32'h8242, st);
		chk("locked word", 32'h5, {16'h0, i_cci_dev_model.mem[5]});
	endtask

	// Ready-pin mode, read of the word that reports a corrected error
	task automatic t_read;
		logic [31:0] st, d;
		logic [1:0]  r;
		wr(A_CFG, {23'h0, 1'b1, 1'b0, DEF_SLAVE}, r);
		rd(A_CFG, d, r);
		chk("cfg", 32'h128, d);
		cmd(8'h16, 16'h0000, st);
		chk("read stat", 32'h8542, st);
		rd(A_DATA, d, r);
		chk("read data", 32'hBEEF, d);
		chk("read fetches", 32'h1, i_cci_dev_model.n_fetch);
		chk("read len", 32'h3, i_cci_dev_model.fetch_len);
	endtask

	task automatic t_rev;
		logic [31:0] st, d;
		logic [1:0]  r;
		wr(A_CMD, {24'h0, CMD_REV}, r);
		wr(A_CMD, {24'h0, CMD_WR_LO}, r);
		poll(st);
		chk("rev stat", 32'h814A, st);
		rd(A_CMD, d, r);
		chk("busy cmd kept", {24'h0, CMD_REV}, d);
		rd(A_DATA, d, r);
		chk("rev data", {24'h0, REV_VAL}, d);
		chk("rev len", 32'h2, i_cci_dev_model.fetch_len);
	endtask

	task automatic t_resume;
		logic [31:0] st, d;
		logic [1:0]  r;
		cmd(CMD_RESUME, 16'h0000, st);
		chk("resume stat", 32'h02, st & 32'h7F);
		wr(A_CMD, {24'h0, CMD_RD_HI}, r);
		rd(A_STAT, d, r);
		chk("after resume", 32'h8, d & 32'h48);
		wr(A_CFG, {25'h0, 7'h27}, r);
		cmd(CMD_ENTER, 16'h0000, st);
		chk("nack stat", 32'h12, st & 32'h7F);
	endtask

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	// Reset for 20 cycles, then the scenarios in order
	initial begin
		err_total = 0;
		cmp_count = 0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_refuse();
		t_enter();
		t_write();
		t_read();
		t_rev();
		t_resume();
		chk("overlap", 32'h0, i_cci_dev_model.overlap);
		end_of_test();
	end
endmodule // cci_ctrl_tb

// file: verif/cci_dev_model.sv
module cci_dev_model
	import cci_pkg::*;
#(
	parameter logic [6:0] ADDR = 7'h28,
	parameter logic [7:0] REV  = 8'h3C, // Arbitrary revision value
	parameter int         BUSY = 2000
) (
	input  wire logic aclk,
	input  wire logic scl,
	input  wire logic sda,
	output logic      sda_pull,
	output logic      ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [32];
	logic [15:0] last_data, dat;
	logic [7:0]  last_cmd, a, c, h, l;
	logic [5:0]  rsp;
	logic        cal, nk;
	int          n_fetch, fetch_len, overlap;

	// Byte in on rising SCL, then the ninth bit is acknowledged unless the address is checked and not ours
	task automatic rx(output logic [7:0] b, input logic chk);
		#1 sda_pull = 1'b0;
		repeat (8) @(posedge scl) b = {b[6:0], sda};
		@(negedge scl) #1 sda_pull = !chk || b[7:1] == ADDR;
		@(negedge scl);
	endtask

	// Byte out, first bit highest, changed only while SCL is low
	task automatic tx(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			#1 sda_pull = !b[i];
			@(negedge scl);
		end
		#1 sda_pull = 1'b0;
		@(posedge scl) nk = sda;
		@(negedge scl);
		fetch_len++;
	endtask

	// One command at a time; the power-up window is taken as always open
	task automatic exec;
		if (!ready) overlap++;
		last_cmd = c;
		last_data = {h, l};
		n_fetch = 0;
		rsp = {4'h0, RC_ACK};
		if (c == CMD_ENTER) cal = 1'b1;
		else if (c <= CMD_RD_HI) begin
			dat = mem[c[4:0]];
			rsp[2] = c[4:0] == 5'h16;
		end else if (c >= CMD_WR_LO && c <= CMD_WR_HI) begin
			if (c[4:0] < 5'h16) rsp[1:0] = 2'h2;
			else mem[c[4:0]] = {h, l};
		end else if (c == CMD_REV) dat = {REV, ~REV};
		else if (c != CMD_RESUME) rsp[1:0] = 2'h2;
		cal = cal && c != CMD_RESUME;
		if (c != CMD_RESUME) begin
			ready = 1'b0;
			fork
				begin
					repeat (c[6] ? 3 * BUSY : BUSY) @(negedge aclk); // Memory writes run longest
					ready = 1'b1;
				end
			join_none
		end
	endtask

	// Serial side: one packet or one fetch per START
	initial begin
		for (int i = 0; i < 32; i++) mem[i] = 16'(i);
		{sda_pull, cal, rsp, dat, last_cmd, last_data} = '0;
		{ready, nk} = 2'b11;
		{n_fetch, fetch_len, overlap} = '0;
		forever begin
			@(negedge sda iff scl === 1'b1);
			rx(a, 1'b1);
			if (a[7:1] == ADDR && !a[0]) begin
				rx(c, 1'b0);
				rx(h, 1'b0);
				rx(l, 1'b0);
				#1 sda_pull = 1'b0;
				exec();
			end else if (a[7:1] == ADDR) begin
				n_fetch++;
				fetch_len = 0;
				tx({cal ? MODE_CAL : 2'h0, rsp[5:2], ready ? rsp[1:0] : RC_BUSY});
				for (int k = 1; k >= 0 && !nk; k--) tx(dat[8*k +: 8]);
			end
		end
	end
endmodule // cci_dev_model
